/* src/rgp_pkg.sv */
// rgp_pkg: shared constants and carriers for the reduced mii / gigabit port
// assumes a single 10 MHz register clock; all pin timing is in cycles of it
package rgp_pkg;

  // clock of the register side
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned CLK_PERIOD_PS = 100_000;

  // reference and interface clock figures, in their own units
  localparam int unsigned REF_CLK_MHZ = 50;
  localparam int unsigned XTAL_MHZ = 25;
  localparam int unsigned DELAY_MIN_PS = 1500;
  // delay taps of one register clock each; a least time rounds up
  localparam int unsigned DELAY_TAPS = (DELAY_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // at 10 Mbps one dibit stands for ten reference cycles
  localparam int unsigned DIBIT_HOLD_10M = 10;
  // edges after release before the synchronised straps are caught
  localparam int unsigned STRAP_SETTLE = 2;

  // interface select strap encodings
  localparam logic [1:0] SEL_RGMII = 2'h3;
  localparam logic [1:0] SEL_RMII = 2'h1;

  // register byte offsets (apb, one word each)
  localparam logic [7:0] OFS_CTRL_FIRST = 8'h00;
  localparam logic [7:0] OFS_CTRL_SECOND = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h0C;

  // first control register fields
  localparam int unsigned F_FORCE_EN = 0;
  localparam int unsigned F_FORCE_SPD = 1;
  localparam int unsigned F_DUPLEX = 3;
  // second control register fields
  localparam int unsigned F_IBS_EN = 2;
  localparam int unsigned F_RX_DLY = 3;
  localparam int unsigned F_TX_DLY = 4;

  // speed codes
  typedef enum logic [1:0] {
    RGP_SPD_10 = 2'h0,
    RGP_SPD_100 = 2'h1,
    RGP_SPD_1000 = 2'h2
  } rgp_speed_e;

  // apb request carrier
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } rgp_apb_req_s;

  // in-band status as seen by software
  typedef struct packed {
    logic link_up;
    logic [1:0] speed;
    logic full_duplex;
  } rgp_ibs_s;

endpackage

/* src/rgp_port.sv */
// rgp_port: port-side logic of the reduced 10/100 and reduced gigabit mac port
// assumes link pins are sampled on pclk through two flops; the analog clock
// paths are modelled by a tap delay and a divider on pclk for simulation
//
// Behaviour
// R1 - reduced 10/100 uses one 50MHz reference
// R2 - separate two-bit transmit and receive paths
// R3 - strap high: external reference clock input used
// R4 - strap low: drive reference out, ignore input
// R5 - tx enable/data in, crs/err/data out
// R6 - external phy wired crosswise by the board
// R7 - gigabit mode runs 10/100/1000, half/full
// R8 - mac side sources the transmit clock
// R9 - device sources receive clock per speed
// R10 - gigabit nibbles on both clock edges; rx_data here changes on rising rx clock edges only
// R11 - control line merges valid and error
// R12 - select strap 11 picks gigabit mode
// R13 - speed strap picks 1000 or 100
// R14 - control register forces 1000/100/10
// R15 - non-status phy should have fixed speed
// R16 - optional delay on tx or rx clock
// R17 - tx delay resets off, rx delay on
// R18 - in-band status adapts speed and duplex; here only link_speed follows it, full_duplex is just read back
// R19 - status enable from strap or bit 2
// R20 - status disabled without a capable phy
// R21 - in-band status readable by software
// R22 - tx pins enter, rx pins leave device
// R23 - dibits sampled on rising reference edge
//
// Decided for this implementation: register access over APB and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module rgp_port
  import rgp_pkg::*;
#(
  parameter int unsigned HOLD_10M = DIBIT_HOLD_10M
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // straps
  input wire logic clock_mode_strap,
  input wire logic [1:0] if_select_strap,
  input wire logic speed_strap,
  // reference clock pins
  input wire logic crystal_input,
  input wire logic ref_clock_in,
  output logic ref_clock_out,
  // transmit pins (into the device)
  input wire logic tx_clock,
  input wire logic tx_ctl,
  input wire logic [3:0] tx_data,
  // receive pins (out of the device)
  output logic rx_clock,
  output logic rx_ctl,
  output logic rx_err,
  output logic [3:0] rx_data,
  // switch-side stream
  output logic sw_rx_valid,
  output logic sw_rx_error,
  output logic [3:0] sw_rx_data,
  input wire logic sw_tx_valid,
  input wire logic sw_tx_error,
  input wire logic [3:0] sw_tx_data,
  // mode readback
  output logic gigabit_mode,
  output logic [1:0] link_speed
);

  // elaboration check: the hold count must fit the counter
  if (HOLD_10M < 1 || HOLD_10M > 255) begin : g_bad_hold
    $error("rgp_port: HOLD_10M out of range");
  end

  // speed choice: software override first, then in-band status, then the strap
  function automatic logic [1:0] spd_from(input logic force_en, input logic [1:0] fspd,
                                          input logic ibs_on, input logic [1:0] ibs_spd,
                                          input logic strap_gig);
    if (force_en) begin
      spd_from = fspd;
    end else if (ibs_on) begin
      spd_from = ibs_spd;
    end else begin
      spd_from = strap_gig ? RGP_SPD_1000 : RGP_SPD_100;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // input synchronisers

  logic [11:0] sync1; // first stage, read only by sync2
  logic [11:0] sync2; // second stage, safe to use
  // straps are pins too, so they ride the same two flops
  wire [11:0] pin_vec = {crystal_input, ref_clock_in, tx_clock, tx_ctl, tx_data,
                         clock_mode_strap, if_select_strap, speed_strap};

  // two flops for every asynchronous pin
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1 <= 12'h000;
      sync2 <= 12'h000;
    end else begin
      sync1 <= pin_vec;
      sync2 <= sync1;
    end
  end

  wire s_xtal = sync2[11];
  wire s_refin = sync2[10];
  wire s_txclk = sync2[9];
  wire s_txctl = sync2[8];
  wire [3:0] s_txd = sync2[7:4];
  wire s_clk_mode = sync2[3];
  wire [1:0] s_if_sel = sync2[2:1];
  wire s_spd_strap = sync2[0];

  ////////////////////////////////////////////////////////////////////////////
  // strap capture after reset release

  logic strap_done; // straps latched once
  logic strap_clk_mode; // clock-mode strap as caught
  logic strap_gig_if; // gigabit interface chosen
  logic strap_gig_spd; // speed strap as caught
  logic [1:0] strap_wait; // edges since release

  // straps are caught once the flops hold them, never in reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_wait <= 2'h0;
      strap_done <= 1'b0;
      strap_clk_mode <= 1'b0;
      strap_gig_if <= 1'b0;
      strap_gig_spd <= 1'b0;
    end else if (!strap_done) begin
      if (strap_wait == 2'(STRAP_SETTLE)) begin
        strap_done <= 1'b1;
        strap_clk_mode <= s_clk_mode; // [R3] [R4]
        strap_gig_if <= (s_if_sel == SEL_RGMII); // [R12]
        strap_gig_spd <= s_spd_strap; // [R13]
      end else begin
        strap_wait <= strap_wait + 2'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers

  logic force_en; // software speed override
  logic [1:0] force_spd; // forced speed code
  logic force_dup; // forced duplex
  logic ibs_sw_en; // software in-band status enable
  logic ibs_sw_set; // software has written the enable
  logic rx_dly_en; // delay receive clock
  logic tx_dly_en; // delay transmit clock
  rgp_ibs_s ibs_stat; // in-band status seen from the phy

  wire wr_acc = psel && penable && pwrite;
  wire hit_c1 = (paddr == OFS_CTRL_FIRST);
  wire hit_c2 = (paddr == OFS_CTRL_SECOND);
  wire hit_st = (paddr == OFS_STATUS);
  wire addr_ok = hit_c1 || hit_c2 || hit_st;

  // register writes; delay bits reset to documented defaults
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      force_en <= 1'b0;
      force_spd <= RGP_SPD_1000;
      force_dup <= 1'b1;
      ibs_sw_en <= 1'b0;
      ibs_sw_set <= 1'b0;
      rx_dly_en <= 1'b1; // [R17]
      tx_dly_en <= 1'b0; // [R17]
    end else if (wr_acc && hit_c1) begin
      force_en <= pwdata[F_FORCE_EN]; // [R14]
      force_spd <= (pwdata[F_FORCE_SPD +: 2] == 2'h3) ? RGP_SPD_1000 : pwdata[F_FORCE_SPD +: 2];
      force_dup <= pwdata[F_DUPLEX];
    end else if (wr_acc && hit_c2) begin
      ibs_sw_en <= pwdata[F_IBS_EN]; // [R19]
      ibs_sw_set <= 1'b1;
      rx_dly_en <= pwdata[F_RX_DLY]; // [R16]
      tx_dly_en <= pwdata[F_TX_DLY]; // [R16]
    end
  end

  // strap gives the default until software writes the bit
  wire ibs_on = ibs_sw_set ? ibs_sw_en : strap_clk_mode; // [R19] [R20]

  // read mux; unmapped addresses read zero with pslverr
  wire [31:0] rd_c1 = {27'h0, force_dup, 1'b0, force_spd, force_en};
  wire [31:0] rd_c2 = {27'h0, tx_dly_en, rx_dly_en, ibs_on, 2'h0};
  wire [31:0] rd_st = {28'h0, ibs_stat}; // [R21]
  wire [31:0] rd_mux = hit_c1 ? rd_c1 : hit_c2 ? rd_c2 : hit_st ? rd_st : 32'h0;

  assign pready = 1'b1; // zero wait states
  assign pslverr = psel && penable && !addr_ok;

  // read data registered in the setup phase so it stands in the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
    end else if (psel && !penable) begin
      prdata <= rd_mux;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // speed selection

  wire gig = strap_gig_if; // [R12]
  wire [1:0] spd = gig ? spd_from(force_en, force_spd, ibs_on, ibs_stat.speed, strap_gig_spd)
                       : (force_en && force_spd == RGP_SPD_10 ? RGP_SPD_10 : RGP_SPD_100);
  assign gigabit_mode = gig;
  assign link_speed = spd; // [R7] [R18]

  ////////////////////////////////////////////////////////////////////////////
  // reference clock and receive clock generation

  logic [1:0] div_cnt; // divider count, tied to zero and unused
  logic ref_out_q; // reference out (toggles on each crystal edge, crystal rate)
  logic [7:0] rxc_cnt; // receive clock period counter
  logic rxc_q; // receive clock before delay
  typedef logic [DELAY_TAPS-1:0] rgp_dly_t; // shift form keeps a single tap legal
  logic [DELAY_TAPS-1:0] rxc_dly; // delay line for rx clock

  // the true 50MHz is a pll off the crystal; here a toggle on crystal edges
  // stands in, which runs at the crystal rate rather than twice it
  logic xtal_d;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xtal_d <= 1'b0;
      ref_out_q <= 1'b0;
    end else begin
      xtal_d <= s_xtal;
      if (s_xtal != xtal_d) begin
        ref_out_q <= ~ref_out_q; // [R4]
      end
    end
  end
  // output only in reduced mode with the clock-mode strap low
  assign ref_clock_out = (!gig && !strap_clk_mode) ? ref_out_q : 1'b0; // [R4]

  // rx clock divider: ratio per speed, scaled to the model clock
  wire [7:0] rxc_half = (spd == RGP_SPD_1000) ? 8'h01 : (spd == RGP_SPD_100) ? 8'h05 : 8'h32;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rxc_cnt <= 8'h00;
      rxc_q <= 1'b0;
      rxc_dly <= '0;
    end else begin
      if (rxc_cnt >= rxc_half - 8'h01) begin
        rxc_cnt <= 8'h00;
        rxc_q <= ~rxc_q; // [R9]
      end else begin
        rxc_cnt <= rxc_cnt + 8'h01;
      end
      rxc_dly <= (rxc_dly << 1) | rgp_dly_t'(rxc_q);
    end
  end
  assign rx_clock = gig ? (rx_dly_en ? rxc_dly[DELAY_TAPS-1] : rxc_q) : 1'b0; // [R16] [R9]
  assign div_cnt = 2'h0;

  ////////////////////////////////////////////////////////////////////////////
  // transmit side: pins into the switch

  logic [DELAY_TAPS-1:0] txc_dly; // optional tx clock delay
  logic txc_prev; // previous effective tx clock
  // reference edge source: external input in normal mode, own clock otherwise
  wire rmii_ref = strap_clk_mode ? s_refin : ref_out_q; // [R3] [R4] [R1]
  wire txc_raw = gig ? s_txclk : rmii_ref; // [R8]
  wire txc_eff = (gig && tx_dly_en) ? txc_dly[DELAY_TAPS-1] : txc_raw; // [R16]
  wire tx_rise = txc_eff && !txc_prev;
  wire tx_fall = !txc_eff && txc_prev;
  logic [7:0] hold_cnt; // 10 Mbps dibit repeat counter
  logic tx_err_q; // error half of the control line

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      txc_dly <= '0;
      txc_prev <= 1'b0;
      hold_cnt <= 8'h00;
      sw_rx_valid <= 1'b0;
      sw_rx_error <= 1'b0;
      sw_rx_data <= 4'h0;
      tx_err_q <= 1'b0;
    end else begin
      txc_dly <= (txc_dly << 1) | rgp_dly_t'(txc_raw);
      txc_prev <= txc_eff;
      if (gig && tx_rise) begin
        sw_rx_valid <= s_txctl; // [R10] [R11] valid on rising edge
        sw_rx_data <= s_txd;
      end else if (gig && tx_fall) begin
        tx_err_q <= s_txctl ^ sw_rx_valid; // [R11] error xor at falling edge
        sw_rx_error <= s_txctl ^ sw_rx_valid;
        if (spd == RGP_SPD_1000) begin
          sw_rx_data <= s_txd; // [R10] second nibble
        end
      end else if (!gig && tx_rise) begin
        // [R23] sample dibit on rising ref edge; 10M takes one per HOLD_10M
        if (spd != RGP_SPD_10 || hold_cnt == 8'h00) begin
          sw_rx_valid <= s_txctl; // [R5] [R22]
          sw_rx_data <= {2'h0, s_txd[1:0]}; // [R2]
          sw_rx_error <= 1'b0;
        end
        hold_cnt <= (hold_cnt >= 8'(HOLD_10M - 1)) ? 8'h00 : hold_cnt + 8'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // receive side: switch out to the pins, and in-band status capture

  logic rx_prev; // previous generated rx clock
  logic [7:0] rx_hold; // 10 Mbps dibit repeat
  wire rx_rise = rxc_q && !rx_prev;
  wire rx_fall = !rxc_q && rx_prev;
  wire ref_rise = tx_rise; // one reference times both directions [R1]

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_prev <= 1'b0;
      rx_hold <= 8'h00;
      rx_ctl <= 1'b0;
      rx_err <= 1'b0;
      rx_data <= 4'h0;
      ibs_stat <= '0;
    end else begin
      rx_prev <= rxc_q;
      if (gig && rx_rise) begin
        rx_ctl <= sw_tx_valid; // [R11] [R10]
        rx_data <= sw_tx_data;
      end else if (gig && rx_fall) begin
        rx_ctl <= sw_tx_valid ^ sw_tx_error; // [R11]
        rx_err <= 1'b0;
      end else if (!gig && ref_rise) begin
        if (spd != RGP_SPD_10 || rx_hold == 8'h00) begin
          rx_ctl <= sw_tx_valid; // [R5] crs/valid
          rx_err <= sw_tx_error; // [R5]
          rx_data <= {2'h0, sw_tx_data[1:0]}; // [R2] [R22]
        end
        rx_hold <= (rx_hold >= 8'(HOLD_10M - 1)) ? 8'h00 : rx_hold + 8'h01;
      end
      // phy sends status in the idle gap: ctl low, data = dup,spd,link
      if (gig && ibs_on && tx_rise && !s_txctl) begin
        ibs_stat.link_up <= s_txd[0]; // [R18] [R21]
        ibs_stat.speed <= (s_txd[2:1] == 2'h3) ? RGP_SPD_1000 : s_txd[2:1];
        ibs_stat.full_duplex <= s_txd[3];
      end
    end
  end

  wire unused_ok = &{1'b0, div_cnt, tx_err_q, force_dup};

endmodule

`default_nettype wire

/* verif/rgp_port_props.sv */
// rgp_port_props: assertions on the port pins and the apb slave
// assumes it is bound into rgp_port and sees only its ports
`timescale 1ns/1ps
`default_nettype none
module rgp_port_props
  import rgp_pkg::*;
#(
  parameter int unsigned HOLD_10M = DIBIT_HOLD_10M
) (
  // clock, reset and bus
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // pins and mode
  input wire logic gigabit_mode,
  input wire logic [1:0] link_speed,
  input wire logic ref_clock_out,
  input wire logic rx_clock,
  input wire logic rx_ctl,
  input wire logic sw_tx_valid
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////
  // decode of the bus address
  wire logic mapped;
  assign mapped = paddr == OFS_CTRL_FIRST || paddr == OFS_CTRL_SECOND || paddr == OFS_STATUS;
  // speed field of the last bus cycle, for the forced speed check
  logic [1:0] last_spd;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) last_spd <= 2'h0;
    else last_spd <= pwdata[F_FORCE_SPD +: 2];
  end
  sequence s_access;
    psel && penable;
  endsequence
  sequence s_force_wr;
    s_access ##0 pwrite && paddr == OFS_CTRL_FIRST && pwdata[F_FORCE_EN] && gigabit_mode;
  endsequence
  ////////////////////////////////
  a_ready_always: assert property (pready) else $error("pready low");
  a_unmapped_err: assert property (s_access ##0 !mapped |-> pslverr) else $error("no slverr");
  a_mapped_ok: assert property (s_access ##0 mapped |-> !pslverr) else $error("bad slverr");
  a_unmapped_zero: assert property (s_access ##0 !mapped && !pwrite |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  a_force_speed: assert property (s_force_wr |=> link_speed == ((last_spd == 2'h3) ? 2'h2 : last_spd))
    else $error("forced speed not taken");
  a_refout_gig: assert property (gigabit_mode |-> !ref_clock_out) else $error("ref out in gigabit");
  a_rxclk_off: assert property (!gigabit_mode |-> !rx_clock) else $error("rx clock outside gigabit");
  a_rxclk_runs: assert property (gigabit_mode |-> ##[1:200] $changed(rx_clock))
    else $error("rx clock stopped");
  a_rx_follow: assert property ($rose(sw_tx_valid) && gigabit_mode |-> ##[1:120] rx_ctl)
    else $error("rx control not raised");
endmodule
bind rgp_port rgp_port_props #(.HOLD_10M(HOLD_10M)) rgp_port_props_i (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .gigabit_mode, .link_speed, .ref_clock_out,
  .rx_clock, .rx_ctl, .sw_tx_valid);
`default_nettype wire

/* verif/rgp_mac_model.sv */
// rgp_mac_model: external mac or phy driving the gigabit transmit pins
// assumes pclk from the bench; pin edges are Q pclk apart
`timescale 1ns/1ps
`default_nettype none
module rgp_mac_model #(
  parameter int Q = 4
) (
  // commands from the bench
  input wire logic pclk,
  input wire logic go,
  input wire logic ctl_rise,
  input wire logic [3:0] nib_rise,
  input wire logic [3:0] nib_fall,
  // transmit pins, into the device
  output logic tx_clock,
  output logic tx_ctl,
  output logic [3:0] tx_data
);
  int cnt = 0;
  initial begin
    tx_clock = 1'b0;
    tx_ctl = 1'b0;
    tx_data = 4'h0;
  end
  // clock stands still outside frames; idle data keeps changing so no stale value passes
  always @(posedge pclk) begin
    if (!go) begin
      cnt <= 0;
      tx_clock <= 1'b0;
      tx_ctl <= 1'b0;
      tx_data <= ~tx_data;
    end else begin
      cnt <= (cnt + 1) % (4 * Q);
      if (cnt == 0) begin
        tx_data <= nib_rise; // first nibble before rising edge
        tx_ctl <= ctl_rise; // valid, unchanged at fall since no error
      end
      if (cnt == Q) tx_clock <= 1'b1; // far side sources the clock
      if (cnt == 2 * Q) tx_data <= nib_fall; // second nibble for falling edge
      if (cnt == 3 * Q) tx_clock <= 1'b0;
    end
  end
endmodule
`default_nettype wire

/* verif/tb_rgp_port.sv */
// tb_rgp_port: apb register tests and link traffic for rgp_port
// assumes a 10 MHz pclk and the mac model on the transmit pins
`timescale 1ns/1ps
`default_nettype none
module tb_rgp_port;
  import rgp_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic clock_mode_strap = 1'b0;
  logic [1:0] if_select_strap = SEL_RGMII;
  logic speed_strap = 1'b1;
  logic crystal_input = 1'b0;
  logic ref_clock_in = 1'b0;
  logic sw_tx_valid = 1'b0;
  logic sw_tx_error = 1'b0;
  logic [3:0] sw_tx_data = 4'h0;
  logic go = 1'b0;
  logic ctl_rise = 1'b0;
  logic [3:0] nib_rise = 4'h0;
  logic [3:0] nib_fall = 4'h0;
  logic [31:0] prdata, r;
  logic pready, pslverr, ref_clock_out, tx_clock, tx_ctl, rx_clock, rx_ctl, rx_err, e, v;
  logic sw_rx_valid, sw_rx_error, gigabit_mode;
  logic [3:0] tx_data, rx_data, sw_rx_data;
  logic [1:0] link_speed;
  int failures = 0;
  int tests_run = 0;
  int n;
  rgp_port #(.HOLD_10M(2)) rgp_port_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .clock_mode_strap, .if_select_strap, .speed_strap, .crystal_input, .ref_clock_in,
    .ref_clock_out, .tx_clock, .tx_ctl, .tx_data, .rx_clock, .rx_ctl, .rx_err, .rx_data, .sw_rx_valid,
    .sw_rx_error, .sw_rx_data, .sw_tx_valid, .sw_tx_error, .sw_tx_data, .gigabit_mode, .link_speed);
  // partner outputs land on device tx inputs, as a crosswise phy wires them
  rgp_mac_model rgp_mac_model_i (.pclk, .go, .ctl_rise, .nib_rise, .nib_fall, .tx_clock, .tx_ctl, .tx_data);
  ////////////////////////////////
  // clocks: pclk and a slow crystal
  initial forever #50 pclk = ~pclk;
  initial forever begin
    repeat (3) @(posedge pclk);
    crystal_input <= ~crystal_input;
  end
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic test_done();
    $display("compares %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // a used-up wait bound is a mismatch and ends the run
  task automatic to(input int k);
    if (k >= 200) begin
      failures++;
      $display("wrong value wait expected done seen timeout");
      test_done();
    end
  endtask
  // one apb transfer, entered just after a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 200);
    to(k);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic do_reset();
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
  endtask
  ////////////////////////////////
  initial begin
    do_reset();
    apb(1'b0, OFS_CTRL_SECOND, 32'h0);
    chk("ctrl2 reset", 32'h08, r & 32'h1C);
    chk("gigabit_mode", 32'h1, 32'(gigabit_mode));
    apb(1'b1, 8'h08, 32'hFFFF_FFFF);
    chk("slverr wr", 32'h1, 32'(e));
    apb(1'b0, 8'h08, 32'h0);
    chk("unmapped rd", 32'h0, r);
    $display("test reset and map done");
    for (int s = 0; s < 4; s++) begin
      apb(1'b1, OFS_CTRL_FIRST, 32'(1 + 2 * s));
      chk("forced speed", (s == 3) ? 32'h2 : 32'(s), 32'(link_speed));
    end
    apb(1'b1, OFS_CTRL_FIRST, 32'h0);
    chk("strap speed", 32'(RGP_SPD_1000), 32'(link_speed));
    apb(1'b1, OFS_CTRL_SECOND, 32'h10);
    apb(1'b0, OFS_CTRL_SECOND, 32'h0);
    chk("delay bits", 32'h10, r & 32'h1C);
    v = rx_clock;
    for (n = 0; n < 200 && rx_clock === v; n++) @(posedge pclk);
    to(n);
    $display("test speed and delay done");
    go <= 1'b1; // partner at one fixed rate, in-band off
    ctl_rise <= 1'b1;
    nib_rise <= 4'h5;
    nib_fall <= 4'hA;
    for (n = 0; n < 200 && sw_rx_valid !== 1'b1; n++) @(posedge pclk);
    to(n);
    chk("sw_rx_data", 32'h5, 32'(sw_rx_data));
    chk("sw_rx_valid", 32'h1, 32'(sw_rx_valid));
    chk("sw_rx_error", 32'h0, 32'(sw_rx_error));
    go <= 1'b0;
    sw_tx_valid <= 1'b1;
    sw_tx_data <= 4'h3;
    for (n = 0; n < 200 && rx_ctl !== 1'b1; n++) @(posedge pclk);
    to(n);
    chk("rx_ctl", 32'h1, 32'(rx_ctl));
    chk("rx_data", 32'h3, 32'(rx_data));
    chk("rx_err", 32'h0, 32'(rx_err));
    sw_tx_valid <= 1'b0;
    $display("test data done");
    apb(1'b1, OFS_CTRL_SECOND, 32'h0C);
    go <= 1'b1;
    ctl_rise <= 1'b0;
    nib_rise <= 4'hB;
    nib_fall <= 4'hB;
    for (n = 0; n < 200; n++) begin
      apb(1'b0, OFS_STATUS, 32'h0);
      if ((r & 32'hF) === 32'hB) break;
    end
    to(n);
    chk("status", 32'hB, r & 32'hF);
    chk("ibs speed", 32'(RGP_SPD_100), 32'(link_speed));
    apb(1'b1, OFS_CTRL_SECOND, 32'h08);
    go <= 1'b0;
    $display("test in-band done");
    if_select_strap <= SEL_RMII;
    do_reset();
    chk("rmii mode", 32'h0, 32'(gigabit_mode));
    v = ref_clock_out;
    for (n = 0; n < 200 && ref_clock_out === v; n++) @(posedge pclk);
    to(n);
    chk("ref out", 32'(!v), 32'(ref_clock_out));
    chk("rmii rx clock", 32'h0, 32'(rx_clock));
    go <= 1'b1;
    ctl_rise <= 1'b1;
    nib_rise <= 4'h2;
    nib_fall <= 4'h2;
    for (n = 0; n < 200 && sw_rx_valid !== 1'b1; n++) @(posedge pclk);
    to(n);
    chk("rmii dibit in", 32'h2, 32'(sw_rx_data));
    go <= 1'b0;
    sw_tx_valid <= 1'b1;
    sw_tx_data <= 4'hD;
    for (n = 0; n < 200 && rx_ctl !== 1'b1; n++) @(posedge pclk);
    to(n);
    chk("rmii dibit out", 32'h1, 32'(rx_data));
    chk("rmii rx_err", 32'h0, 32'(rx_err));
    sw_tx_valid <= 1'b0;
    $display("test reduced mode done");
    test_done();
  end
endmodule
`default_nettype wire
